// ===== verilog/urm_uart_regs.sv
// urm_uart_regs: register map, fifo control and fifos of one asynchronous serial channel
//
// Contract
// - fifo_control write-only, shares offset with identification
// - bit 0 enables both fifos, else holding
// - other bits ignored unless bit 0 set
// - fifo enable change empties both fifos
// - bit 1 flushes receive fifo, self-clearing
// - bit 2 flushes transmit fifo, self-clearing
// - bit 3 selects dma signalling mode 1
// - bits 4 and 5 reserved, no effect
// - bits 7:6 pick trigger 1/4/8/14
// - data bit 0 is lsb, first serial
// - non-fifo: ident 3,6,7 and fifo-error zero
// - line_control bit 7 banks divisor at 0/1
// - receive interrupt follows occupancy against threshold in fifo mode, any byte otherwise
// - fifo mode: time-out reported as 1100
`timescale 1ns/1ps
`default_nettype none
module urm_uart_regs (
	input wire logic clk,
	input wire logic srst,
	input wire logic host_cs,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [2:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	input wire logic rx_char_valid,
	input wire logic [7:0] rx_char,
	input wire logic [2:0] rx_char_err,
	input wire logic rx_timeout,
	output logic tx_char_valid,
	output logic [7:0] tx_char,
	input wire logic tx_char_ready,
	input wire logic tx_shift_idle,
	input wire logic [3:0] modem_in,
	output logic irq,
	output logic receive_dma_request,
	output logic transmit_dma_request,
	output logic [7:0] line_control_out,
	output logic [7:0] modem_control_out,
	output logic [15:0] divisor_out
);
	import urm_pkg::*;

	urm_state_t r, n;
	logic [RX_W-1:0] rx_q;
	logic [7:0] tx_q;
	logic acc_rd, acc_wr, divisor_access_select;
	logic rx_flush, tx_flush, rx_push, rx_pop, tx_push, tx_pop, buf_deq;
	logic lsr_rd, msr_rd, iir_rd, ovf, thre_set, thre_clr;
	logic [3:0] rx_base_wr, rx_base_rd, tx_base_wr, tx_base_rd;
	logic [4:0] rx_base_cnt, rx_base_err, tx_base_cnt, trig_n, trig_r;
	logic [2:0] head_err;
	logic ls_pend, rda_pend, to_pend, thre_pend, ms_pend;
	logic [3:0] iir_code;
	logic [7:0] rd_val;
	logic [1:0] buf_after;

	////////////////////////////////////////////////////////////////
	// helpers

	// storage limit: sixteen words, or a single holding byte in compatibility mode
	function automatic logic [4:0] fifo_cap(input logic en);
		return en ? FIFO_DEPTH : HOLD_DEPTH;
	endfunction

	// receive threshold from the two trigger select bits
	function automatic logic [4:0] trig_level(input logic [1:0] sel);
		case (sel)
			2'b00: return TRIG_01;
			2'b01: return TRIG_04;
			2'b10: return TRIG_08;
			default: return TRIG_14;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	// fifo storage: receive words carry the error bits beside the character
	urm_fifo_mem #(.W(RX_W), .AW(FIFO_AW)) u_rx_mem (
		.clk(clk),
		.we(rx_push),
		.waddr(rx_base_wr),
		.wdata({rx_char_err, rx_char}),
		.raddr(n.rx_rd),
		.rdata(rx_q)
	);

	urm_fifo_mem #(.W(8), .AW(FIFO_AW)) u_tx_mem (
		.clk(clk),
		.we(tx_push),
		.waddr(tx_base_wr),
		.wdata(host_wdata),
		.raddr(n.tx_rd),
		.rdata(tx_q)
	);

	////////////////////////////////////////////////////////////////
	// interrupt sources and identification, from registered state and the rx_timeout input
	always_comb begin
		head_err = (r.rx_cnt != 5'h00) ? rx_q[10:8] : 3'b000;
		trig_r = trig_level(r.trig);
		ls_pend = r.interrupt_enable[IER_LS_BIT] & (r.oe | (|head_err));
		// fifo mode compares occupancy against threshold; level drops below it
		rda_pend = r.interrupt_enable[IER_RDA_BIT] & (r.fifo_en ? (r.rx_cnt >= trig_r) : (r.rx_cnt != 5'h00));
		to_pend = r.interrupt_enable[IER_RDA_BIT] & r.fifo_en & rx_timeout & (r.rx_cnt != 5'h00);
		thre_pend = r.interrupt_enable[IER_THRE_BIT] & r.thre_int;
		ms_pend = r.interrupt_enable[IER_MS_BIT] & (|r.msr_delta);
		if (ls_pend) begin
			iir_code = IIR_LS;
		end else if (to_pend) begin
			iir_code = IIR_TMO; // bit 3 with bit 2, only reachable in fifo mode
		end else if (rda_pend) begin
			iir_code = IIR_RDA;
		end else if (thre_pend) begin
			iir_code = IIR_THRE;
		end else if (ms_pend) begin
			iir_code = IIR_MS;
		end else begin
			iir_code = IIR_NONE;
		end
	end

	////////////////////////////////////////////////////////////////
	// next-state logic: host decode, fifo pointers, status and outputs
	always_comb begin
		n = r;
		acc_rd = host_cs & host_rd;
		acc_wr = host_cs & host_wr;
		divisor_access_select = r.line_control[LCR_DIVISOR_ACCESS_SELECT_BIT];
		rx_flush = 1'b0;
		tx_flush = 1'b0;
		tx_push = 1'b0;
		rx_pop = 1'b0;
		lsr_rd = 1'b0;
		msr_rd = 1'b0;
		iir_rd = 1'b0;
		rd_val = 8'h00;

		// host writes; divisor latches banked over offsets 0 and 1
		if (acc_wr) begin
			if (host_addr == OFF_DATA && !divisor_access_select) begin
				tx_push = 1'b1;
			end else if (host_addr == OFF_DATA) begin
				n.dll = host_wdata;
			end else if (host_addr == OFF_IER && !divisor_access_select) begin
				n.interrupt_enable = host_wdata[3:0];
			end else if (host_addr == OFF_IER) begin
				n.divisor_high = host_wdata;
			end else if (host_addr == OFF_FCR) begin
				// a write here lands in fifo_control, never in identification
				n.fifo_en = host_wdata[FCR_EN_BIT];
				if (host_wdata[FCR_EN_BIT]) begin
					// other fields only programmed alongside the enable
					rx_flush = host_wdata[FCR_RX_FLUSH_BIT];
					tx_flush = host_wdata[FCR_TX_FLUSH_BIT];
					n.dma_mode = host_wdata[FCR_DMA_BIT];
					n.trig = host_wdata[FCR_TRIG_LSB +: 2];
					// bits 5:4 are not looked at
				end
				if (host_wdata[FCR_EN_BIT] != r.fifo_en) begin
					// mode change: drop both queues so capacities stay consistent
					rx_flush = 1'b1;
					tx_flush = 1'b1;
				end
			end else if (host_addr == OFF_LCR) begin
				n.line_control = host_wdata;
			end else if (host_addr == OFF_MCR) begin
				n.modem_control = host_wdata & MCR_MASK;
			end else if (host_addr == OFF_SCR) begin
				n.scratch_pad = host_wdata;
			end
		end

		// host reads with their side effects
		if (acc_rd) begin
			if (host_addr == OFF_DATA && !divisor_access_select) begin
				rd_val = rx_q[7:0]; // bit 0 is the first bit received
				rx_pop = (r.rx_cnt != 5'h00);
			end else if (host_addr == OFF_DATA) begin
				rd_val = r.dll;
			end else if (host_addr == OFF_IER && !divisor_access_select) begin
				rd_val = {4'h0, r.interrupt_enable};
			end else if (host_addr == OFF_IER) begin
				rd_val = r.divisor_high;
			end else if (host_addr == OFF_FCR) begin
				// identification; fifo-enabled bits zero in compatibility mode
				rd_val = {r.fifo_en, r.fifo_en, 2'b00, iir_code};
				iir_rd = 1'b1;
			end else if (host_addr == OFF_LCR) begin
				rd_val = r.line_control;
			end else if (host_addr == OFF_MCR) begin
				rd_val = r.modem_control;
			end else if (host_addr == OFF_LSR) begin
				// fifo-error bit forced low outside fifo mode
				rd_val = {r.fifo_en & (r.rx_err_cnt != 5'h00),
					(r.tx_cnt == 5'h00) & (r.buf_cnt == 2'b00) & tx_shift_idle,
					r.tx_cnt == 5'h00, head_err, r.oe, r.rx_cnt != 5'h00};
				lsr_rd = 1'b1;
			end else if (host_addr == OFF_MSR) begin
				rd_val = {modem_in, r.msr_delta};
				msr_rd = 1'b1;
			end else begin
				rd_val = r.scratch_pad;
			end
			n.rdata = rd_val;
		end

		// receive fifo: flush resets pointers and counters only, the shifter is outside
		rx_base_wr = rx_flush ? 4'h0 : r.rx_wr;
		rx_base_rd = rx_flush ? 4'h0 : r.rx_rd;
		rx_base_cnt = rx_flush ? 5'h00 : r.rx_cnt;
		rx_base_err = rx_flush ? 5'h00 : r.rx_err_cnt;
		rx_pop = rx_pop & ~rx_flush;
		// no credit for a same-cycle pop: an arriving byte never passes the limit
		rx_push = rx_char_valid & (rx_base_cnt < fifo_cap(n.fifo_en));
		ovf = rx_char_valid & ~rx_push;
		n.rx_wr = rx_base_wr + {3'b000, rx_push};
		n.rx_rd = rx_base_rd + {3'b000, rx_pop};
		n.rx_cnt = rx_base_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
		n.rx_err_cnt = rx_base_err + {4'h0, rx_push & (|rx_char_err)}
			- {4'h0, rx_pop & (|rx_q[10:8])};

		// transmit fifo: flush leaves the two words already handed to the shifter
		tx_base_wr = tx_flush ? 4'h0 : r.tx_wr;
		tx_base_rd = tx_flush ? 4'h0 : r.tx_rd;
		tx_base_cnt = tx_flush ? 5'h00 : r.tx_cnt;
		tx_push = tx_push & (tx_base_cnt < fifo_cap(n.fifo_en));
		tx_pop = ~tx_flush & (r.tx_cnt != 5'h00) & (r.buf_cnt != 2'b10);
		n.tx_wr = tx_base_wr + {3'b000, tx_push};
		n.tx_rd = tx_base_rd + {3'b000, tx_pop};
		n.tx_cnt = tx_base_cnt + {4'h0, tx_push} - {4'h0, tx_pop};

		// two-entry buffer toward the shifter; a stalled shifter backs up the fifo
		buf_deq = r.buf_valid & tx_char_ready;
		buf_after = r.buf_cnt - {1'b0, buf_deq};
		if (buf_deq) begin
			n.buf0 = r.buf1;
		end
		if (tx_pop && buf_after == 2'b00) begin
			n.buf0 = tx_q; // lsb leaves first on the line
		end else if (tx_pop) begin
			n.buf1 = tx_q;
		end
		n.buf_cnt = buf_after + {1'b0, tx_pop};
		n.buf_valid = (n.buf_cnt != 2'b00);

		// overrun: a new overrun in the clearing read still wins
		n.oe = (r.oe & ~lsr_rd) | ovf;

		// transmit-empty interrupt: raised on emptying, on enabling, on fifo mode change
		thre_set = (n.tx_cnt == 5'h00) & (~r.tx_empty_d
			| (n.interrupt_enable[IER_THRE_BIT] & ~r.interrupt_enable[IER_THRE_BIT]) | (n.fifo_en != r.fifo_en));
		thre_clr = tx_push | (iir_rd & (iir_code == IIR_THRE));
		n.thre_int = (r.thre_int & ~thre_clr) | thre_set;
		n.tx_empty_d = (n.tx_cnt == 5'h00);

		// modem deltas: sticky, a change during the clearing read is kept
		n.primed = 1'b1;
		n.modem_prev = modem_in;
		if (r.primed) begin
			n.msr_delta = (r.msr_delta & {4{~msr_rd}})
				| {modem_in[3] ^ r.modem_prev[3], ~modem_in[2] & r.modem_prev[2],
				modem_in[1] ^ r.modem_prev[1], modem_in[0] ^ r.modem_prev[0]};
		end else if (msr_rd) begin
			n.msr_delta = 4'h0;
		end

		// dma request pins: mode 1 only while the fifos are on
		trig_n = trig_level(n.trig);
		if (n.fifo_en && n.dma_mode) begin
			n.rx_dma = r.rx_dma ? (n.rx_cnt != 5'h00)
				: ((n.rx_cnt >= trig_n) | (rx_timeout & (n.rx_cnt != 5'h00)));
			n.tx_dma = (n.tx_cnt != FIFO_DEPTH);
		end else begin
			n.rx_dma = (n.rx_cnt != 5'h00);
			n.tx_dma = (n.tx_cnt == 5'h00);
		end

		// interrupt pin mirrors a pending identification, one cycle late
		n.irq = (iir_code != IIR_NONE);
	end

	////////////////////////////////////////////////////////////////
	// the single state register
	always_ff @(posedge clk) begin
		if (srst) begin
			r <= STATE_RESET;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs, all taken from state flip-flops
	assign host_rdata = r.rdata;
	assign tx_char_valid = r.buf_valid;
	assign tx_char = r.buf0;
	assign irq = r.irq;
	assign receive_dma_request = r.rx_dma;
	assign transmit_dma_request = r.tx_dma;
	assign line_control_out = r.line_control;
	assign modem_control_out = r.modem_control;
	assign divisor_out = {r.divisor_high, r.dll};

endmodule
`default_nettype wire

// ===== pkg/urm_pkg.sv
// urm_pkg: offsets, field positions, codes and reset state of the uart register map block
package urm_pkg;

	// register offsets on the three-bit host address
	localparam logic [2:0] OFF_DATA = 3'h0;
	localparam logic [2:0] OFF_IER = 3'h1;
	localparam logic [2:0] OFF_FCR = 3'h2;
	localparam logic [2:0] OFF_LCR = 3'h3;
	localparam logic [2:0] OFF_MCR = 3'h4;
	localparam logic [2:0] OFF_LSR = 3'h5;
	localparam logic [2:0] OFF_MSR = 3'h6;
	localparam logic [2:0] OFF_SCR = 3'h7;

	// fifo_control bit positions, and the line_control divisor bank bit
	localparam int FCR_EN_BIT = 0;
	localparam int FCR_RX_FLUSH_BIT = 1;
	localparam int FCR_TX_FLUSH_BIT = 2;
	localparam int FCR_DMA_BIT = 3;
	localparam int FCR_TRIG_LSB = 6;
	localparam int LCR_DIVISOR_ACCESS_SELECT_BIT = 7;

	// interrupt_enable bit positions
	localparam int IER_RDA_BIT = 0;
	localparam int IER_THRE_BIT = 1;
	localparam int IER_LS_BIT = 2;
	localparam int IER_MS_BIT = 3;

	// modem_control bits 7:6 read as zero
	localparam logic [7:0] MCR_MASK = 8'h3f;

	// fifo geometry and receive trigger thresholds
	localparam int FIFO_AW = 4;
	localparam int RX_W = 11;
	localparam logic [4:0] FIFO_DEPTH = 5'h10;
	localparam logic [4:0] HOLD_DEPTH = 5'h01;
	localparam logic [4:0] TRIG_01 = 5'h01;
	localparam logic [4:0] TRIG_04 = 5'h04;
	localparam logic [4:0] TRIG_08 = 5'h08;
	localparam logic [4:0] TRIG_14 = 5'h0e;

	// interrupt_identify low nibble codes
	localparam logic [3:0] IIR_NONE = 4'h1;
	localparam logic [3:0] IIR_LS = 4'h6;
	localparam logic [3:0] IIR_RDA = 4'h4;
	localparam logic [3:0] IIR_TMO = 4'hc;
	localparam logic [3:0] IIR_THRE = 4'h2;
	localparam logic [3:0] IIR_MS = 4'h0;

	typedef struct packed {
		logic [3:0] interrupt_enable;
		logic [7:0] line_control;
		logic [7:0] modem_control;
		logic [7:0] scratch_pad;
		logic [7:0] dll;
		logic [7:0] divisor_high;
		logic fifo_en;
		logic dma_mode;
		logic [1:0] trig;
		logic [3:0] rx_wr;
		logic [3:0] rx_rd;
		logic [4:0] rx_cnt;
		logic [4:0] rx_err_cnt;
		logic [3:0] tx_wr;
		logic [3:0] tx_rd;
		logic [4:0] tx_cnt;
		logic oe;
		logic thre_int;
		logic tx_empty_d;
		logic [3:0] msr_delta;
		logic [3:0] modem_prev;
		logic primed;
		logic rx_dma;
		logic tx_dma;
		logic irq;
		logic [7:0] rdata;
		logic [7:0] buf0;
		logic [7:0] buf1;
		logic [1:0] buf_cnt;
		logic buf_valid;
	} urm_state_t;

	// everything cleared except the transmit-empty history
	localparam urm_state_t STATE_RESET = '{tx_empty_d: 1'b1, default: '0};

endpackage

// ===== verilog/urm_fifo_mem.sv
// urm_fifo_mem: small fifo storage array with registered read data and write bypass
`timescale 1ns/1ps
`default_nettype none
module urm_fifo_mem #(
	parameter int W = 8,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);

	logic [W-1:0] mem [0:(1<<AW)-1];

	////////////////////////////////////////////////////////////////
	// write port, and read of the next head; the bypass keeps a word
	// written into the head slot visible without a cycle of stale data
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		if (we && waddr == raddr) begin
			rdata <= wdata;
		end else begin
			rdata <= mem[raddr];
		end
	end

endmodule
`default_nettype wire

// ===== sim/urm_uart_regs_monitor.sv
// urm_uart_regs_monitor: port-level checks on the register map and fifo control
`timescale 1ns/1ps
`default_nettype none
module urm_uart_regs_monitor (
	input wire logic clk,
	input wire logic srst,
	input wire logic host_cs,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [2:0] host_addr,
	input wire logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata,
	input wire logic rx_char_valid,
	input wire logic rx_timeout,
	input wire logic receive_dma_request,
	input wire logic transmit_dma_request,
	input wire logic [7:0] line_control_out,
	input wire logic [15:0] divisor_out
);
	import urm_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic rd_iir, wr_fcr, wr_lo, wr_hi;
	// decoded host accesses
	assign rd_iir = host_cs && host_rd && host_addr == OFF_FCR;
	assign wr_fcr = host_cs && host_wr && host_addr == OFF_FCR;
	assign wr_lo = host_cs && host_wr && host_addr == OFF_DATA;
	assign wr_hi = host_cs && host_wr && host_addr == OFF_IER;
	////////////////////////////////////////////////////////////////
	// read data lands a cycle late, so a following read would hide it
	sequence s_iir_read; rd_iir ##1 !(host_cs && host_rd); endsequence
	sequence s_rx_flush;
		wr_fcr && host_wdata[1:0] == 2'b11 && !rx_char_valid && !rx_timeout ##1 !rx_char_valid && !rx_timeout;
	endsequence
	sequence s_tx_flush; wr_fcr && host_wdata[0] && host_wdata[2] ##1 !(host_cs && host_wr); endsequence
	property p_iir_rsvd; s_iir_read |=> host_rdata[5:4] == 2'b00; endproperty
	property p_iir_compat; s_iir_read |=> host_rdata[7] == host_rdata[6] && (host_rdata[7] || !host_rdata[3]); endproperty
	property p_iir_tmo; s_iir_read |=> !host_rdata[3] || host_rdata[2:0] == 3'h4; endproperty
	property p_div_lo; wr_lo && line_control_out[7] |=> divisor_out[7:0] == $past(host_wdata); endproperty
	property p_div_hi; wr_hi && line_control_out[7] |=> divisor_out[15:8] == $past(host_wdata); endproperty
	property p_div_keep; (wr_lo || wr_hi) && !line_control_out[7] |=> $stable(divisor_out); endproperty
	property p_rx_flush; s_rx_flush |=> !receive_dma_request; endproperty
	property p_tx_flush; s_tx_flush |=> transmit_dma_request; endproperty
	a_iir_rsvd: assert property (p_iir_rsvd) else $error("ident bits 5:4 set");
	a_iir_compat: assert property (p_iir_compat) else $error("ident fifo bits wrong");
	a_iir_tmo: assert property (p_iir_tmo) else $error("ident bit 3 without 2");
	a_div_lo: assert property (p_div_lo) else $error("divisor low not written");
	a_div_hi: assert property (p_div_hi) else $error("divisor high not written");
	a_div_keep: assert property (p_div_keep) else $error("divisor changed while unbanked");
	a_rx_flush: assert property (p_rx_flush) else $error("receive request after flush");
	a_tx_flush: assert property (p_tx_flush) else $error("transmit request low after flush");
endmodule
////////////////////////////////////////////////////////////////
// attach to every register map instance
bind urm_uart_regs urm_uart_regs_monitor mon (.clk(clk), .srst(srst), .host_cs(host_cs), .host_rd(host_rd),
	.host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
	.rx_char_valid(rx_char_valid), .rx_timeout(rx_timeout), .receive_dma_request(receive_dma_request),
	.transmit_dma_request(transmit_dma_request), .line_control_out(line_control_out), .divisor_out(divisor_out));
`default_nettype wire

// ===== sim/urm_serial_peer.sv
// urm_serial_peer: serializer stand-in that takes transmit words and can stall
`timescale 1ns/1ps
`default_nettype none
module urm_serial_peer (
	input wire logic clk,
	input wire logic srst,
	input wire logic stall,
	input wire logic tx_char_valid,
	input wire logic [7:0] tx_char,
	output var logic tx_char_ready,
	output logic tx_shift_idle,
	output var int n_taken,
	output var logic [7:0] last_char
);
	int busy = 0;
	// ready moves off the sampling edge only
	always @(negedge clk) begin
		tx_char_ready <= !stall;
	end
	// a taken word keeps the shifter busy a few cycles
	// one process owns the counters, so a bench reset clears them without a second driver
	always @(posedge clk) begin
		if (srst) begin
			n_taken <= 0;
			last_char <= 8'h00;
			busy <= 0;
		end else if (tx_char_valid && tx_char_ready) begin
			n_taken <= n_taken + 1;
			last_char <= tx_char;
			busy <= 3;
		end else if (busy > 0) begin
			busy <= busy - 1;
		end
	end
	assign tx_shift_idle = (busy == 0);
endmodule
`default_nettype wire

// ===== sim/urm_uart_regs_test.sv
// urm_uart_regs_test: directed tests of register map, fifo control and fifos
`timescale 1ns/1ps
`default_nettype none
module urm_uart_regs_test;
	import urm_pkg::*;
	logic clk, srst, host_cs, host_rd, host_wr, rx_char_valid, rx_timeout, stall;
	logic tx_char_valid, tx_char_ready, tx_shift_idle, irq, rx_dma, tx_dma;
	logic [2:0] host_addr;
	logic [7:0] host_wdata, host_rdata, rx_char, tx_char, last_char, rd_val, lcr_out;
	logic [15:0] divisor_out;
	int n_mismatch, comparisons, n_taken;
	// error and modem inputs stay quiet: their logic is outside this block's tests
	urm_uart_regs dut (.clk(clk), .srst(srst), .host_cs(host_cs), .host_rd(host_rd), .host_wr(host_wr),
		.host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata), .rx_char_valid(rx_char_valid),
		.rx_char(rx_char), .rx_char_err(3'h0), .rx_timeout(rx_timeout), .tx_char_valid(tx_char_valid),
		.tx_char(tx_char), .tx_char_ready(tx_char_ready), .tx_shift_idle(tx_shift_idle), .modem_in(4'h0),
		.irq(irq), .receive_dma_request(rx_dma), .transmit_dma_request(tx_dma), .line_control_out(lcr_out),
		.modem_control_out(), .divisor_out(divisor_out));
	urm_serial_peer peer (.clk(clk), .srst(srst), .stall(stall), .tx_char_valid(tx_char_valid), .tx_char(tx_char),
		.tx_char_ready(tx_char_ready), .tx_shift_idle(tx_shift_idle), .n_taken(n_taken), .last_char(last_char));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// one host cycle; released data is inverted so nothing stale looks valid
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk);
		{host_cs, host_wr, host_addr, host_wdata} = {2'b11, a, d};
		@(negedge clk);
		{host_cs, host_wr, host_wdata} = {2'b00, ~d};
	endtask
	task automatic rd(input logic [2:0] a);
		@(negedge clk);
		{host_cs, host_rd, host_addr} = {2'b11, a};
		@(negedge clk);
		{host_cs, host_rd} = 2'b00;
		@(negedge clk);
		rd_val = host_rdata;
	endtask
	task automatic rxc(input logic [7:0] d);
		@(negedge clk);
		{rx_char_valid, rx_char} = {1'b1, d};
		@(negedge clk);
		{rx_char_valid, rx_char} = {1'b0, ~d};
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_bank;
		rd(OFF_FCR);
		chk("identify", 8'h01, rd_val);
		wr(OFF_LCR, 8'h83);
		wr(OFF_DATA, 8'h34);
		wr(OFF_IER, 8'h12);
		chk("div_low", 8'h34, divisor_out[7:0]);
		rd(OFF_IER);
		chk("div_high", 8'h12, rd_val);
		wr(OFF_LCR, 8'h03);
		chk("line_ctl", 8'h03, lcr_out);
		wr(OFF_IER, 8'h08);
		rd(OFF_IER);
		chk("int_enable", 8'h08, rd_val);
		chk("div_kept", 8'h12, divisor_out[15:8]);
		wr(OFF_IER, 8'h00);
		wr(OFF_FCR, 8'h31);
		rd(OFF_FCR);
		chk("ident_fifo", 8'hc1, rd_val);
		wr(OFF_FCR, 8'hce);
		rd(OFF_FCR);
		chk("ident_off", 8'h01, rd_val);
		$display("bank test done");
	endtask
	// every trigger code, time-out report, then both flush paths
	task automatic t_rx;
		logic [4:0] lvl [4];
		lvl = '{TRIG_01, TRIG_04, TRIG_08, TRIG_14};
		wr(OFF_IER, 8'h01);
		for (int i = 0; i < 4; i++) begin
			wr(OFF_FCR, {i[1:0], 6'h03});
			for (int j = 1; j < lvl[i]; j++) begin
				rxc(j[7:0]);
			end
			repeat (3) @(negedge clk);
			chk("irq_below", 8'h00, {7'h00, irq});
			rxc(8'h5a);
			repeat (3) @(negedge clk);
			chk("irq_level", 8'h01, {7'h00, irq});
		end
		chk("rx_dma_mode0", 8'h01, {7'h00, rx_dma});
		rx_timeout = 1'b1;
		rd(OFF_FCR);
		chk("ident_tmo", 8'hcc, rd_val);
		rx_timeout = 1'b0;
		rd(OFF_DATA);
		chk("rx_head", 8'h01, rd_val);
		repeat (3) @(negedge clk);
		chk("irq_drop", 8'h00, {7'h00, irq});
		wr(OFF_FCR, 8'h03);
		rd(OFF_LSR);
		chk("ready_flush", 8'h00, {7'h00, rd_val[0]});
		rxc(8'h77);
		wr(OFF_FCR, 8'h00);
		rd(OFF_LSR);
		chk("ready_disable", 8'h00, {7'h00, rd_val[0]});
		wr(OFF_IER, 8'h00);
		$display("receive test done");
	endtask
	// stalled serializer: dma modes, then a transmit flush
	task automatic t_tx;
		stall = 1'b1;
		wr(OFF_FCR, 8'h07);
		wr(OFF_DATA, 8'ha5);
		wr(OFF_DATA, 8'h3c);
		wr(OFF_DATA, 8'h0f);
		repeat (3) @(negedge clk);
		chk("tx_head", 8'ha5, tx_char);
		chk("tx_dma0", 8'h00, {7'h00, tx_dma});
		wr(OFF_FCR, 8'h09);
		repeat (2) @(negedge clk);
		chk("tx_dma1", 8'h01, {7'h00, tx_dma});
		wr(OFF_FCR, 8'h05);
		rd(OFF_LSR);
		chk("thr_empty", 8'h01, {7'h00, rd_val[5]});
		stall = 1'b0;
		repeat (8) @(negedge clk);
		chk("sent", 8'h02, n_taken[7:0]);
		chk("last", 8'h3c, last_char);
		$display("transmit test done");
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		{srst, host_cs, host_rd, host_wr, rx_char_valid, rx_timeout, stall} = 7'h40;
		{host_addr, host_wdata, rx_char} = '0;
		n_mismatch = 0;
		comparisons = 0;
		repeat (6) @(negedge clk);
		srst = 1'b0;
		t_bank();
		t_rx();
		t_tx();
		end_sim();
	end
	// the tests need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end
endmodule
`default_nettype wire
